/* File: logic/usb_regs_pkg.sv */
// Package: register map, field positions, reset values and carrier types
`default_nettype none
package usb_regs_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CONFIG_REPORT  = 8'h00;  // Build options, read only
    localparam logic [7:0] OFF_DEVICE_CONTROL = 8'h04;  // Device control
    localparam logic [7:0] OFF_EP_FIFO_BASE   = 8'h20;  // Endpoint 0 port; endpoint n at base + 4n
    localparam int         NUM_EP             = 5;      // Endpoints 0 through 4

    // ------------------------------------------------------------
    // Configuration report field positions
    // ------------------------------------------------------------
    localparam int CFG_RX_MERGE_BIT  = 7;
    localparam int CFG_TX_SPLIT_BIT  = 6;
    localparam int CFG_BIG_ENDIAN    = 5;
    localparam int CFG_HB_ISO_RX_BIT = 4;
    localparam int CFG_HB_ISO_TX_BIT = 3;
    localparam int CFG_DYN_FIFO_BIT  = 2;
    localparam int CFG_SOFT_CONN_BIT = 1;
    localparam int CFG_PATH_WIDE_BIT = 0;
    localparam logic [7:0] CONFIG_REPORT_RESET = 8'h06;  // Dynamic sizing and soft connect built in

    // ------------------------------------------------------------
    // Device control field positions
    // ------------------------------------------------------------
    localparam int DC_ROLE_B_BIT    = 7;
    localparam int DC_FULL_SPD_BIT  = 6;
    localparam int DC_LOW_SPD_BIT   = 5;
    localparam int DC_VBUS_HI       = 4;
    localparam int DC_VBUS_LO       = 3;
    localparam int DC_HOST_BIT      = 2;
    localparam int DC_RESERVED_BIT  = 1;
    localparam int DC_SESSION_BIT   = 0;
    localparam logic [1:0] DC_SW_RESET = 2'h0;   // Session and reserved bits after reset
    localparam logic [7:0] DC_STATUS_RESET = 8'h00;

    // Bus voltage level encoding
    localparam logic [1:0] VBUS_BELOW_SESS_END = 2'h0;
    localparam logic [1:0] VBUS_ABOVE_SESS_END = 2'h1;
    localparam logic [1:0] VBUS_ABOVE_A_VALID  = 2'h2;
    localparam logic [1:0] VBUS_ABOVE_BUS_VALID = 2'h3;

    localparam logic [31:0] DATA_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0]  ep;    // Endpoint number
        logic [31:0] data;  // Word
    } ep_word_t;

    typedef struct packed {
        logic       role_is_b;
        logic       full_speed_detected;
        logic       low_speed_detected;
        logic [1:0] vbus_level;
        logic       acting_as_host;
    } link_status_t;

    // APB slave state
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_DONE = 2'b11
    } apb_state_t;

endpackage
`default_nettype wire

/* File: logic/sync2.sv */
// Two flip-flop synchroniser for a bus of levels from outside the clock domain
`default_nettype none
module sync2
#(
    parameter int W = 1
)
(
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;  // First stage, read only by the second

    // ------------------------------------------------------------
    // Two stages
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_q   <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

/* File: logic/skid_buf2.sv */
// Two-entry buffer with valid/ready on both sides
`default_nettype none
module skid_buf2
    import usb_regs_pkg::*;
(
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // Fill side
    input  wire logic               in_valid,
    output logic                    in_ready,
    input  wire usb_regs_pkg::ep_word_t in_word,
    // Drain side
    output logic                    out_valid,
    input  wire logic               out_ready,
    output usb_regs_pkg::ep_word_t  out_word
);
    ep_word_t   mem_q [2];   // Two storage slots
    logic       wr_ptr_q;    // Next slot to fill
    logic       rd_ptr_q;    // Next slot to drain
    logic [1:0] count_q;     // Words held

    // ------------------------------------------------------------
    // Handshake decode
    // ------------------------------------------------------------
    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;
    assign in_ready  = (count_q != 2'h2);
    assign out_valid = (count_q != 2'h0);
    assign out_word  = mem_q[rd_ptr_q];

    // Pointers and count; a full buffer stalls the filler
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q  <= 2'h0;
        end
        else
        begin
            wr_ptr_q <= wr_ptr_q ^ push;
            rd_ptr_q <= rd_ptr_q ^ pop;
            count_q  <= count_q + {1'b0, push} - {1'b0, pop};
        end
    end

    // Storage, written only on accepted words
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
        end
        else if (push)
        begin
            mem_q[wr_ptr_q] <= in_word;
        end
    end
endmodule
`default_nettype wire

/* File: logic/usb_config_fifo_device_control_regs.sv */
// APB register slice: build options report, endpoint FIFO ports, device control
`default_nettype none

// Summary of operation
// - Bit 7 reports receive bulk merging
// - Bit 6 reports transmit bulk splitting
// - Bit 5 reports byte order, big=1
// - Bits 4,3 report high-bandwidth iso rx/tx
// - Bit 2 reports dynamic FIFO sizing, resets 1
// - Bit 1 reports soft connect, resets 1
// - Bit 0 reports transceiver path width
// - Port write pushes endpoint transmit FIFO
// - Port read pops endpoint receive FIFO
// - Five endpoint ports, each read returning rx_data from the receive FIFO
// - Device control status bits are read only
// - Session and reserved bits are read/write
// - Two bits encode bus voltage level
// - Role bit: 0 A device, 1 B
module usb_config_fifo_device_control_regs
    import usb_regs_pkg::*;
(
    // Clock and reset
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    // APB slave
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [7:0]               paddr,
    input  wire logic [31:0]              pwdata,
    output logic [31:0]                   prdata,
    output logic                          pready,
    output logic                          pslverr,
    // Build straps, sampled once after reset release
    input  wire logic [7:0]               build_options,
    // Transmit FIFO side (to endpoint FIFOs)
    output logic                          tx_valid,
    input  wire logic                     tx_ready,
    output usb_regs_pkg::ep_word_t        tx_word,
    // Receive FIFO side (from endpoint FIFOs)
    output logic                          rx_pop,
    output logic [2:0]                    rx_pop_ep,
    input  wire logic                     rx_valid,
    input  wire logic [31:0]              rx_data,
    // Transceiver status pins
    input  wire usb_regs_pkg::link_status_t link_status_async,
    // Session control out to the transceiver
    output logic                          session_req
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    apb_state_t   state_q;          // APB access sequencer
    apb_state_t   state_d;
    logic [7:0]   config_q;         // Captured build options
    logic         strap_taken_q;    // Straps sampled once
    logic [1:0]   dc_sw_q;          // Session and reserved bits
    logic [31:0]  prdata_q;         // Read data register
    logic         pready_q;
    logic         pslverr_q;
    logic         rx_pop_q;
    logic [2:0]   rx_pop_ep_q;
    logic         session_q;
    link_status_t status_s;         // Synchronised pin status
    logic         buf_in_ready;
    logic         buf_out_valid;
    ep_word_t     buf_out_word;
    logic         tx_valid_q;
    ep_word_t     tx_word_q;

    // ------------------------------------------------------------
    // Pin status synchroniser
    // ------------------------------------------------------------
    sync2 #(.W($bits(link_status_t))) u_sync
    (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (link_status_async),
        .sync_out (status_s)
    );

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire        setup      = psel && !penable;
    wire        hit_cfg    = (paddr == OFF_CONFIG_REPORT);
    wire        hit_dc     = (paddr == OFF_DEVICE_CONTROL);
    wire [7:0]  ep_off     = paddr - OFF_EP_FIFO_BASE;
    wire        hit_ep     = (paddr >= OFF_EP_FIFO_BASE) && (ep_off[1:0] == 2'h0)
                             && (ep_off[7:2] < 6'(NUM_EP));
    wire [2:0]  ep_num     = ep_off[4:2];
    wire        mapped     = hit_cfg || hit_dc || hit_ep;
    // A port write must wait for buffer room; a read for receive data
    wire        ep_wr_go   = pwrite && hit_ep && buf_in_ready;
    wire        ep_rd_go   = !pwrite && hit_ep && rx_valid;
    wire        plain_go   = !hit_ep;
    wire        can_finish = plain_go || ep_wr_go || ep_rd_go;
    wire        finish     = (state_q == ST_WAIT) && can_finish;

    // Device control read value: status from pins, software bits stored
    wire [7:0]  dc_read = {status_s.role_is_b,
                           status_s.full_speed_detected,
                           status_s.low_speed_detected,
                           status_s.vbus_level,
                           status_s.acting_as_host,
                           dc_sw_q};

    wire [31:0] rd_mux = hit_cfg ? {24'h00_0000, config_q} :
                         hit_dc  ? {24'h00_0000, dc_read}  :
                         hit_ep  ? rx_data                 :
                                   DATA_RESET;

    // ------------------------------------------------------------
    // APB sequencer: setup, wait for the side to be ready, answer
    // ------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: if (setup) state_d = ST_WAIT;
            ST_WAIT: if (can_finish) state_d = ST_DONE;
            ST_DONE: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_q <= ST_IDLE;
        else
            state_q <= state_d;
    end

    // Answer registers: pready is high for exactly the closing cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= DATA_RESET;
        end
        else
        begin
            pready_q  <= finish;
            pslverr_q <= finish && !mapped;
            if (finish && !pwrite)
                prdata_q <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // Build options: caught once after reset, never writable
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            config_q      <= CONFIG_REPORT_RESET;
            strap_taken_q <= 1'b0;
        end
        else if (!strap_taken_q)
        begin
            // Straps settle through reset; sampling after release avoids a port in reset
            config_q      <= build_options;
            strap_taken_q <= 1'b1;
        end
        // No write path reaches config_q
    end

    // ------------------------------------------------------------
    // Device control software bits
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dc_sw_q   <= DC_SW_RESET;
            session_q <= 1'b0;
        end
        else if (finish && pwrite && hit_dc)
        begin
            dc_sw_q   <= pwdata[DC_RESERVED_BIT:DC_SESSION_BIT];
            session_q <= pwdata[DC_SESSION_BIT];
        end
    end

    // ------------------------------------------------------------
    // Receive pop strobe, one cycle per completed port read
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_pop_q    <= 1'b0;
            rx_pop_ep_q <= 3'h0;
        end
        else
        begin
            rx_pop_q    <= finish && ep_rd_go;
            rx_pop_ep_q <= ep_num;
        end
    end

    // ------------------------------------------------------------
    // Transmit path: buffer absorbs stalls, output stage registered
    // ------------------------------------------------------------
    wire      out_take = !tx_valid_q || tx_ready;
    ep_word_t push_word;
    assign push_word.ep   = ep_num;
    assign push_word.data = pwdata;

    skid_buf2 u_buf
    (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (finish && ep_wr_go),
        .in_ready  (buf_in_ready),
        .in_word   (push_word),
        .out_valid (buf_out_valid),
        .out_ready (out_take),
        .out_word  (buf_out_word)
    );

    // Output register keeps tx_* straight from flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_valid_q <= 1'b0;
            tx_word_q  <= '0;
        end
        else if (out_take)
        begin
            tx_valid_q <= buf_out_valid;
            tx_word_q  <= buf_out_word;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata      = prdata_q;
    assign pready      = pready_q;
    assign pslverr     = pslverr_q;
    assign tx_valid    = tx_valid_q;
    assign tx_word     = tx_word_q;
    assign rx_pop      = rx_pop_q;
    assign rx_pop_ep   = rx_pop_ep_q;
    assign session_req = session_q;

endmodule
`default_nettype wire

/* File: test/usb_regs_checker.sv */
// Checker: bus timing and register map properties of the register slice
`default_nettype none
module usb_regs_checker
    import usb_regs_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Register bus
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    // Far side
    input  wire logic [7:0]  build_options,
    input  wire logic        tx_valid,
    input  wire logic        rx_pop,
    input  wire logic [2:0]  rx_pop_ep,
    input  wire logic        session_req
);
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire logic is_fifo = paddr[7:5] == 3'h1 && paddr[4:2] <= 3'h4 && paddr[1:0] == 2'h0;
    wire logic is_bad  = paddr == 8'h08 || paddr >= 8'h40;  // Holes we probe
    wire logic done    = psel && penable && pready;
    // The pop strobe is launched on the same edge as pready, so both stand together
    wire logic rd_done = done && !pwrite && is_fifo;
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    AST_CFG_VALUE: assert property (done && !pwrite && paddr == OFF_CONFIG_REPORT |-> prdata == {24'h0, build_options})
        else $error("config report read wrong");
    AST_CFG_RO: assert property (done && pwrite && paddr == OFF_CONFIG_REPORT |=> $stable(session_req))
        else $error("config write disturbed state");
    AST_SESSION: assert property (done && pwrite && paddr == OFF_DEVICE_CONTROL |=> session_req == $past(pwdata[0]))
        else $error("session bit not written");
    AST_DC_UPPER: assert property (done && !pwrite && paddr == OFF_DEVICE_CONTROL |-> prdata[31:8] == 24'h0)
        else $error("device control upper bits set");
    AST_REG_LAT: assert property (psel && !penable && paddr[7:3] == 5'h0 && paddr[1:0] == 2'h0 |-> ##2 pready)
        else $error("register answer late");
    AST_PUSH: assert property (done && pwrite && is_fifo |-> ##[0:3] tx_valid)
        else $error("port write not pushed");
    AST_POP: assert property (rd_done |-> rx_pop && rx_pop_ep == paddr[4:2])
        else $error("port read not popped");
    AST_POP_CAUSE: assert property (rx_pop |-> rd_done)
        else $error("pop without read");
    AST_MAP: assert property (done && is_fifo |-> !pslverr)
        else $error("port refused");
    AST_BAD: assert property (done && is_bad |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("hole accepted");
endmodule
bind usb_config_fifo_device_control_regs usb_regs_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .build_options(build_options), .tx_valid(tx_valid), .rx_pop(rx_pop),
    .rx_pop_ep(rx_pop_ep), .session_req(session_req));
`default_nettype wire

/* File: test/ep_fifo_model.sv */
// Partner model: endpoint FIFOs behind the register slice
`default_nettype none
module ep_fifo_model
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Bench controls
    input  wire logic        stall,
    input  wire logic        rx_avail,
    input  wire logic [2:0]  rx_ep,
    // Transmit side
    output logic             tx_ready,
    // Receive side
    input  wire logic        rx_pop,
    input  wire logic [2:0]  rx_pop_ep,
    output logic             rx_valid,
    output logic [31:0]      rx_data
);
    logic [15:0] cnt_q [5];  // Words popped per endpoint
    logic [31:0] word;       // Head word of the selected endpoint
    // Room in the transmit FIFO comes and goes with the bench
    assign tx_ready = !stall;
    assign word     = {5'h0, rx_ep, 8'ha5, cnt_q[rx_ep]};
    assign rx_valid = rx_avail;
    // Inverted while empty so an early sample reads wrong
    assign rx_data  = rx_avail ? word : ~word;
    // A pop advances that endpoint only
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            foreach (cnt_q[i]) cnt_q[i] <= 16'h0;
        else if (rx_pop)
            cnt_q[rx_pop_ep] <= cnt_q[rx_pop_ep] + 16'h1;
endmodule
`default_nettype wire

/* File: test/usb_config_fifo_device_control_regs_tb.sv */
// Testbench: register slice with endpoint FIFO partner and random traffic
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; $display("Error at %0t: %h vs %h", $time, a, b); end end
module usb_config_fifo_device_control_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import usb_regs_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr, build_options, bo;
    logic [31:0] pwdata, prdata, rd, wd;
    logic tx_valid, tx_ready, rx_pop, rx_valid, session_req, stall, hold_tx, rx_avail;
    logic [2:0] rx_pop_ep, rx_ep, e;
    logic [31:0] rx_data;
    ep_word_t tx_word, w;
    link_status_t link, lk;
    ep_word_t exp_q[$];
    logic [15:0] pops[5];
    int mismatches, checks_done, cycles;
    usb_config_fifo_device_control_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .build_options(build_options), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_word(tx_word),
        .rx_pop(rx_pop), .rx_pop_ep(rx_pop_ep), .rx_valid(rx_valid), .rx_data(rx_data),
        .link_status_async(link), .session_req(session_req));
    ep_fifo_model far_u (.pclk(pclk), .presetn(presetn), .stall(stall), .rx_avail(rx_avail), .rx_ep(rx_ep),
        .tx_ready(tx_ready), .rx_pop(rx_pop), .rx_pop_ep(rx_pop_ep), .rx_valid(rx_valid), .rx_data(rx_data));
    // ------------------------------------------------------------
    // Clock, stall pattern, timeout
    // ------------------------------------------------------------
    always #12.5 pclk = ~pclk;
    always @(posedge pclk)
        stall <= hold_tx || ($urandom % 4 == 0);
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            final_report();
        end
    end
    // Every word leaving the slice must be the next one written
    always @(posedge pclk)
        if (presetn === 1'b1 && tx_valid === 1'b1 && tx_ready === 1'b1)
        begin
            `CHK(tx_word, exp_q.size() ? exp_q[0] : 'x)
            if (exp_q.size())
                void'(exp_q.pop_front());
        end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] exp_rx(input logic [2:0] ep, input logic [15:0] n);
        return {5'h0, ep, 8'ha5, n};
    endfunction
    // One bus transfer; waits for the answer, no fixed latency assumed
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Ends on pready; only the bench timeout ends this wait if pready never comes
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic final_report();
        if (mismatches == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Main sequence: two resets, documented straps then random ones
    // ------------------------------------------------------------
    initial
    begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        build_options = 8'h06; link = '0; stall = 0; hold_tx = 0; rx_avail = 0; rx_ep = 0;
        void'($urandom(32'hb6dd5f45));
        for (int pass = 0; pass < 2; pass++)
        begin
            bo = pass ? 8'($urandom) : CONFIG_REPORT_RESET;
            presetn <= 1'b0;
            build_options <= bo;
            link <= '0;
            foreach (pops[i]) pops[i] = 16'h0;
            repeat (10) @(posedge pclk);
            presetn <= 1'b1;
            repeat (2) @(posedge pclk);
            `CHK(prdata, DATA_RESET)
            apb(0, OFF_DEVICE_CONTROL, 0);
            `CHK(rd, 32'h0)
            apb(0, OFF_CONFIG_REPORT, 0);
            `CHK(rd, {24'h0, bo})
            apb(1, OFF_CONFIG_REPORT, ~{24'h0, bo});
            apb(0, OFF_CONFIG_REPORT, 0);
            `CHK(rd, {24'h0, bo})
            // Every bus level code with random role, speed and host bits
            for (int v = 0; v < 8; v++)
            begin
                lk = 6'($urandom);
                lk.vbus_level = 2'(v);
                wd = $urandom;
                link <= lk;
                repeat (4) @(posedge pclk);
                apb(1, OFF_DEVICE_CONTROL, wd);
                apb(0, OFF_DEVICE_CONTROL, 0);
                `CHK(rd, {24'h0, lk, wd[1:0]})
                `CHK(session_req, wd[0])
            end
            // Fill the buffer against a stalled far side, then random stalls
            hold_tx <= 1'b1;
            for (int k = 0; k < 12; k++)
            begin
                w.ep = 3'(k % 5);
                w.data = (k == 0) ? 32'hffff_ffff : $urandom;
                exp_q.push_back(w);
                fork
                    apb(1, OFF_EP_FIFO_BASE + 8'(4 * (k % 5)), w.data);
                    if (k == 2)
                    begin
                        repeat (10) @(posedge pclk);
                        hold_tx <= 1'b0;
                    end
                join
                `CHK(err, 1'b0)
            end
            repeat (30) @(posedge pclk);
            `CHK(exp_q.size(), 0)
            // Port reads, some waiting for the receive FIFO to fill
            for (int k = 0; k < 10; k++)
            begin
                e = 3'(k % 5);
                rx_ep <= e;
                rx_avail <= (k % 3 != 0);
                fork
                    apb(0, OFF_EP_FIFO_BASE + 8'(4 * (k % 5)), 0);
                    begin
                        repeat (6) @(posedge pclk);
                        rx_avail <= 1'b1;
                    end
                join
                `CHK(rd, exp_rx(e, pops[e]))
                pops[e]++;
                @(posedge pclk);
            end
            // Holes in the map are refused
            apb(0, 8'h08, 0);
            `CHK({err, rd}, {1'b1, 32'h0})
            apb(1, 8'h40 + 8'($urandom % 192), $urandom);
            `CHK(err, 1'b1)
        end
        final_report();
    end
endmodule
`default_nettype wire
